// ### src/aes_axis_outputs.sv
// Top of the four-axis encoder counting and status output block.
// Assumes clock is the internal system clock, already half the input
// clock, and that pulse generator status arrives as synchronous levels.
// Notes on behaviour
// - Pulse-direction mode drives direction on minus pin
// - Encoder mode decodes A/B into counts
// - Up pulse rising edge increments real counter
// - Down pulse rising edge decrements real counter
// - Drive-active high while pulses emitted
// - Drive-active high during home search
// - Interpolating axes hold drive-active high while interpolation runs
// - Optional in-position wait extends drive-active
// - Shared pin gives deviation clear when selected
// - Shared pin defaults to drive-active after reset
// - Selected axis upper outputs follow data bits 11..8
// - Upper outputs low during reset
// - Status mode output 7 flags deceleration
// - Status mode output 6 flags acceleration
// - Status mode output 5 flags below lower compare
// - Status mode output 4 flags above upper compare
// - Everything runs on the half-rate system clock
`timescale 1ns/100ps
`default_nettype none
module aes_axis_outputs (
  input wire logic clock, // System clock, 100 MHz
  input wire logic resetn, // Async active-low reset
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic irq, // Level interrupt
  input wire logic [3:0] pulseDrive, // Pulses being emitted per axis
  input wire logic [3:0] homeSearch, // Home search active per axis
  input wire logic [3:0] interpAxis, // Axis in interpolation
  input wire logic [3:0] interpRun, // Interpolation drive running
  input wire logic [3:0] driveDir, // Drive direction, 1 minus
  input wire logic [3:0] minusPulse, // Minus pulse from generator
  input wire logic [3:0] devClearReq, // Home search clear request
  input wire logic [3:0] decelerating, // Axis in deceleration
  input wire logic [3:0] accelerating, // Axis in acceleration
  input wire logic [127:0] logicalPos, // Logical counters, 32 each
  input wire logic [3:0] phase_a_or_up_count_in, // Phase A or up
  input wire logic [3:0] phase_b_or_down_count_in, // Phase B or down
  input wire logic [3:0] in_position_in, // In-position inputs
  output logic [3:0] minus_pulse_or_direction_out, // Minus or dir
  output logic [3:0] drive_active_out, // Drive or clear shared pin
  output logic [15:0] general_outputs_upper // Outputs 7..4 per axis
);
  // Control and data registers
  logic [6:0] ctrl_r; // Mode control bits
  logic [3:0] axisSel_r; // Command axis register axis bits
  logic [3:0] outData_r; // Output data register bits 11..8
  logic signed [31:0] cmpLo_r; // Lower compare value
  logic signed [31:0] cmpHi_r; // Upper compare value
  logic [15:0] status_r; // Sticky events, 4 per axis
  logic [15:0] mask_r; // Interrupt mask
  logic [15:0] manualOut_r; // Manual upper outputs per axis
  logic [1:0] posSel_r; // Axis shown at position readback
  logic ack_r; // Access answered this cycle
  // Decoded access strobes
  wire logic access = (avs_read | avs_write) & ~ack_r;
  // Writes land at the answer edge, while the master still holds data
  wire logic wrCtrl = avs_write & ack_r &
    (avs_address == aes_pkg::OFF_CTRL);
  wire logic wrAxis = avs_write & ack_r &
    (avs_address == aes_pkg::OFF_AXIS);
  wire logic wrOut = avs_write & ack_r &
    (avs_address == aes_pkg::OFF_OUTDATA);
  wire logic wrLo = avs_write & ack_r &
    (avs_address == aes_pkg::OFF_CMPLO);
  wire logic wrHi = avs_write & ack_r &
    (avs_address == aes_pkg::OFF_CMPHI);
  wire logic wrMask = avs_write & ack_r &
    (avs_address == aes_pkg::OFF_MASK);
  wire logic rdStatus = avs_read & access &
    (avs_address == aes_pkg::OFF_STATUS);
  // Merge write data by byte lane
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction
  // Per-axis working signals
  logic signed [31:0] realPos_r [4]; // Real position counters
  logic [3:0] inposWait_r; // Waiting for in-position
  logic [3:0] cmpLoOut_r; // Held below-lower state
  logic [3:0] cmpHiOut_r; // Held above-upper state
  logic [3:0] driveLvl_r; // Previous drive-active level
  wire logic [3:0] pulsing; // Drive activity sources
  wire logic [3:0] inposActive; // In-position at active level
  wire logic [3:0] driveActive; // Drive-active level
  wire logic [15:0] events; // New events this cycle
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gAxis
      aes_counter_if cif ();
      wire logic signed [31:0] cmpSrc; // Counter under compare
      wire logic [3:0] upperNxt; // Next upper outputs
      aes_input_decoder uDec (
        .clock(clock),
        .resetn(resetn),
        .upDownMode(ctrl_r[aes_pkg::CTL_UPDOWN]),
        .phaseAIn(phase_a_or_up_count_in[g]),
        .phaseBIn(phase_b_or_down_count_in[g]),
        .cnt(cif.source)
      );
      // Activity sources of drive-active
      assign pulsing[g] = pulseDrive[g] | homeSearch[g] |
        (interpAxis[g] & interpRun[g]);
      assign inposActive[g] = in_position_in[g] ==
        ctrl_r[aes_pkg::CTL_INPOSHI];
      assign driveActive[g] = pulsing[g] | inposWait_r[g];
      assign cmpSrc = ctrl_r[aes_pkg::CTL_CMPREAL] ? realPos_r[g] :
        $signed(logicalPos[g*32 +: 32]);
      // Status mode or manual outputs, order 7,6,5,4
      assign upperNxt = ctrl_r[aes_pkg::CTL_STATMODE] ?
        {decelerating[g] & pulsing[g],
         accelerating[g] & pulsing[g],
         cmpLoOut_r[g], cmpHiOut_r[g]} : manualOut_r[g*4 +: 4];
      assign events[g*4 + aes_pkg::EV_DRVEND] =
        driveLvl_r[g] & ~driveActive[g];
      assign events[g*4 + aes_pkg::EV_CMPLO] = ~cmpLoOut_r[g] &
        (cmpSrc < cmpLo_r);
      assign events[g*4 + aes_pkg::EV_CMPHI] = ~cmpHiOut_r[g] &
        (cmpSrc > cmpHi_r);
      assign events[g*4 + aes_pkg::EV_CNTERR] = cif.countErr;
      // Counter, compare state and pin registers
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          realPos_r[g] <= 32'sh00000000;
          inposWait_r[g] <= 1'b0;
          cmpLoOut_r[g] <= 1'b0;
          cmpHiOut_r[g] <= 1'b0;
          driveLvl_r[g] <= 1'b0;
          general_outputs_upper[g*4 +: 4] <= 4'h0;
          drive_active_out[g] <= 1'b0;
          minus_pulse_or_direction_out[g] <= 1'b0;
        end else begin
          if (cif.countUp & ~cif.countDown) begin
            realPos_r[g] <= realPos_r[g] + 32'sh00000001;
          end else if (cif.countDown & ~cif.countUp) begin
            realPos_r[g] <= realPos_r[g] - 32'sh00000001;
          end
          // Wait for in-position after pulsing ends
          if (pulsing[g]) begin
            inposWait_r[g] <= ctrl_r[aes_pkg::CTL_INPOSEN];
          end else if (inposActive[g] |
            ~ctrl_r[aes_pkg::CTL_INPOSEN]) begin
            inposWait_r[g] <= 1'b0;
          end
          // Equal values leave levels alone
          if (cmpSrc < cmpLo_r) begin
            cmpLoOut_r[g] <= 1'b1;
          end else if (cmpSrc > cmpLo_r) begin
            cmpLoOut_r[g] <= 1'b0;
          end
          if (cmpSrc > cmpHi_r) begin
            cmpHiOut_r[g] <= 1'b1;
          end else if (cmpSrc < cmpHi_r) begin
            cmpHiOut_r[g] <= 1'b0;
          end
          driveLvl_r[g] <= driveActive[g];
          general_outputs_upper[g*4 +: 4] <= upperNxt;
          drive_active_out[g] <= ctrl_r[aes_pkg::CTL_DCCSEL] ?
            devClearReq[g] : driveActive[g];
          minus_pulse_or_direction_out[g] <=
            ctrl_r[aes_pkg::CTL_PULSEDIR] ? driveDir[g] :
            minusPulse[g];
        end
      end
    end
  endgenerate
  // Write data merged with old contents
  wire logic [31:0] ctrlMerged = merge({25'h0, ctrl_r}, avs_writedata,
    avs_byteenable);
  wire logic [31:0] axisMerged = merge({20'h0, axisSel_r, 8'h0},
    avs_writedata, avs_byteenable);
  wire logic [31:0] outMerged = merge({20'h0, outData_r, 8'h0},
    avs_writedata, avs_byteenable);
  wire logic [31:0] maskMerged = merge({16'h0, mask_r}, avs_writedata,
    avs_byteenable);
  // Manual outputs of selected axes follow the output data
  logic [15:0] manualNxt;
  always_comb begin
    manualNxt = manualOut_r;
    for (int i = 0; i < 4; i++) begin
      if (wrOut & axisSel_r[i]) begin
        manualNxt[i*4 +: 4] = outMerged[aes_pkg::OUTD_LSB +: 4];
      end
    end
  end
  // Read multiplexer, unmapped reads give zero
  logic [31:0] readNxt;
  always_comb begin
    if (avs_address == aes_pkg::OFF_CTRL) begin
      readNxt = {25'h0, ctrl_r};
    end else if (avs_address == aes_pkg::OFF_AXIS) begin
      readNxt = {20'h0, axisSel_r, 6'h0, posSel_r};
    end else if (avs_address == aes_pkg::OFF_OUTDATA) begin
      readNxt = {20'h0, outData_r, 8'h0};
    end else if (avs_address == aes_pkg::OFF_CMPLO) begin
      readNxt = cmpLo_r;
    end else if (avs_address == aes_pkg::OFF_CMPHI) begin
      readNxt = cmpHi_r;
    end else if (avs_address == aes_pkg::OFF_REALPOS) begin
      readNxt = realPos_r[posSel_r];
    end else if (avs_address == aes_pkg::OFF_STATUS) begin
      readNxt = {16'h0, status_r};
    end else if (avs_address == aes_pkg::OFF_MASK) begin
      readNxt = {16'h0, mask_r};
    end else if (avs_address == aes_pkg::OFF_LOGPOS) begin
      readNxt = logicalPos[posSel_r*32 +: 32];
    end else begin
      readNxt = aes_pkg::UNMAPPED_DATA;
    end
  end
  // Bus handshake: one wait cycle, answer on second edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_r <= access;
      avs_waitrequest <= ~access;
      avs_readdata <= readNxt;
    end
  end
  // Software registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= aes_pkg::CTL_RESET;
      axisSel_r <= 4'h0;
      posSel_r <= 2'h0;
      outData_r <= 4'h0;
      cmpLo_r <= 32'sh00000000;
      cmpHi_r <= 32'sh00000000;
      mask_r <= 16'h0000;
      manualOut_r <= 16'h0000;
    end else begin
      if (wrCtrl) ctrl_r <= ctrlMerged[6:0];
      if (wrAxis) begin
        axisSel_r <= axisMerged[aes_pkg::AXIS_LSB +: 4];
        posSel_r <= axisMerged[1:0];
      end
      if (wrOut) outData_r <= outMerged[aes_pkg::OUTD_LSB +: 4];
      if (wrLo) cmpLo_r <= merge(cmpLo_r, avs_writedata, avs_byteenable);
      if (wrHi) cmpHi_r <= merge(cmpHi_r, avs_writedata, avs_byteenable);
      if (wrMask) mask_r <= maskMerged[15:0];
      manualOut_r <= manualNxt;
    end
  end
  // Sticky status: read clears, a new event wins over the clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_r <= 16'h0000;
      irq <= 1'b0;
    end else begin
      status_r <= (rdStatus ? 16'h0000 : status_r) | events;
      irq <= |(((rdStatus ? 16'h0000 : status_r) | events) & mask_r);
    end
  end
endmodule
`default_nettype wire

// ### src/aes_pkg.sv
// Package for the per-axis encoder and status output block.
// Assumes one system clock; register offsets are word aligned bytes.
package aes_pkg;
  // Register byte offsets
  localparam logic [5:0] OFF_CTRL = 6'h00; // Axis mode control
  localparam logic [5:0] OFF_AXIS = 6'h04; // Command axis register
  localparam logic [5:0] OFF_OUTDATA = 6'h08; // Output data register
  localparam logic [5:0] OFF_CMPLO = 6'h0c; // Lower compare value
  localparam logic [5:0] OFF_CMPHI = 6'h10; // Upper compare value
  localparam logic [5:0] OFF_REALPOS = 6'h14; // Real position counter
  localparam logic [5:0] OFF_STATUS = 6'h18; // Sticky event status
  localparam logic [5:0] OFF_MASK = 6'h1c; // Interrupt mask
  localparam logic [5:0] OFF_LOGPOS = 6'h20; // Logical position input
  // Control field positions
  localparam int CTL_PULSEDIR = 0; // Pulse plus direction mode
  localparam int CTL_UPDOWN = 1; // Up/down count input mode
  localparam int CTL_INPOSEN = 2; // In-position wait enable
  localparam int CTL_INPOSHI = 3; // In-position active level
  localparam int CTL_DCCSEL = 4; // Shared pin acts as deviation clear
  localparam int CTL_STATMODE = 5; // Drive status output mode
  localparam int CTL_CMPREAL = 6; // Compare real, else logical
  localparam logic [6:0] CTL_RESET = 7'h00; // Control reset value
  // Output data field
  localparam int OUTD_LSB = 8; // Upper outputs from bits 11..8
  // Axis select bits in command axis register
  localparam int AXIS_LSB = 8; // Axis bits 11..8, one bit per axis, any number set
  // Status event bits
  localparam int EV_DRVEND = 0; // Drive active fell
  localparam int EV_CMPLO = 1; // Lower compare became true
  localparam int EV_CMPHI = 2; // Upper compare became true
  localparam int EV_CNTERR = 3; // Illegal encoder transition
  localparam int NUM_EV = 4; // Event count
  localparam int NUM_AXES = 4; // Axis count
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000; // Unmapped read
  // Position state type
  typedef logic signed [31:0] aes_pos_t;
endpackage

// ### src/aes_counter_if.sv
// Interface carrying one axis's count events to the real counter.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface aes_counter_if;
  logic countUp; // One-cycle increment
  logic countDown; // One-cycle decrement
  logic countErr; // Illegal quadrature step
  modport source (output countUp, output countDown, output countErr);
  modport sink (input countUp, input countDown, input countErr);
endinterface
`default_nettype wire

// ### src/aes_input_decoder.sv
// Input decoder of one axis: synchroniser, edge and quadrature logic.
// Assumes pins already re-timed to the system clock domain edge.
`timescale 1ns/100ps
`default_nettype none
module aes_input_decoder (
  input wire logic clock, // System clock
  input wire logic resetn, // Async active-low reset
  input wire logic upDownMode, // Up/down pulse mode select
  input wire logic phaseAIn, // Phase A or up pulse
  input wire logic phaseBIn, // Phase B or down pulse
  aes_counter_if.source cnt // Count events out
);
  logic [1:0] syncA_r; // Two-stage synchroniser A
  logic [1:0] syncB_r; // Two-stage synchroniser B
  logic prevA_r; // Last settled A
  logic prevB_r; // Last settled B
  wire logic riseA; // Up pulse edge
  wire logic riseB; // Down pulse edge
  wire logic [3:0] quadStep; // Old and new phase pair
  wire logic quadUp; // Quadrature forward step
  wire logic quadDown; // Quadrature reverse step
  // Synchronise then remember settled level
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      syncA_r <= 2'h0;
      syncB_r <= 2'h0;
      prevA_r <= 1'b0;
      prevB_r <= 1'b0;
    end else begin
      syncA_r <= {syncA_r[0], phaseAIn};
      syncB_r <= {syncB_r[0], phaseBIn};
      prevA_r <= syncA_r[1];
      prevB_r <= syncB_r[1];
    end
  end
  // Edge and step detection uses only the second stage
  assign riseA = syncA_r[1] & ~prevA_r;
  assign riseB = syncB_r[1] & ~prevB_r;
  assign quadStep = {prevA_r, prevB_r, syncA_r[1], syncB_r[1]};
  // Forward Gray order 00-10-11-01 (A leads B)
  assign quadUp = (quadStep == 4'h2) || (quadStep == 4'hb) ||
    (quadStep == 4'hd) || (quadStep == 4'h4);
  assign quadDown = (quadStep == 4'h1) || (quadStep == 4'h7) ||
    (quadStep == 4'he) || (quadStep == 4'h8);
  // Select event source by input mode
  assign cnt.countUp = upDownMode ? riseA : quadUp;
  assign cnt.countDown = upDownMode ? riseB : quadDown;
  assign cnt.countErr = ~upDownMode & ((quadStep == 4'h3) ||
    (quadStep == 4'hc) || (quadStep == 4'h6) || (quadStep == 4'h9));
endmodule
`default_nettype wire

// ### testbench/aes_axis_monitor.sv
// Checker of bus handshake and pin relations of the axis block.
// Assumes bind to aes_axis_outputs; mode is shadowed from bus writes.
`timescale 1ns/100ps
`default_nettype none
module aes_axis_monitor (
  input wire logic clock, // System clock
  input wire logic resetn, // Async reset
  input wire logic [5:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic [3:0] pulseDrive, // Pulsing
  input wire logic [3:0] homeSearch, // Home search
  input wire logic [3:0] interpAxis, // Interp axis
  input wire logic [3:0] interpRun, // Interp run
  input wire logic [3:0] driveDir, // Direction
  input wire logic [3:0] minusPulse, // Minus pulse
  input wire logic [3:0] devClearReq, // Clear request
  input wire logic [3:0] decelerating, // Decel
  input wire logic [3:0] accelerating, // Accel
  input wire logic [3:0] minus_pulse_or_direction_out, // Minus pin
  input wire logic [3:0] drive_active_out, // Shared pin
  input wire logic [15:0] general_outputs_upper // Outputs 7..4
);
  logic [6:0] ctrl_r; // Shadow of control
  logic [3:0] busy; // Any drive activity
  assign busy = pulseDrive | homeSearch | (interpAxis & interpRun);
  // Control shadow updates at the answer edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= 7'h00;
    end else if (avs_write && !avs_waitrequest &&
                 avs_address == aes_pkg::OFF_CTRL) begin
      ctrl_r <= avs_writedata[6:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  bus_answer_a: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  unmapped_zero_a: assert property (avs_read && avs_waitrequest &&
    avs_address == 6'h3c |=> avs_readdata == aes_pkg::UNMAPPED_DATA)
    else $error("unmapped read not zero");
  minus_dir_a: assert property ($past(resetn) && $past(ctrl_r[0])
    |-> minus_pulse_or_direction_out == $past(driveDir))
    else $error("direction level wrong");
  minus_pass_a: assert property ($past(resetn) && !$past(ctrl_r[0])
    |-> minus_pulse_or_direction_out == $past(minusPulse))
    else $error("minus pulse wrong");
  drive_level_a: assert property ($past(resetn) &&
    $past(ctrl_r[4:2]) == 3'h0 |-> drive_active_out == $past(busy))
    else $error("drive active wrong");
  dev_clear_a: assert property ($past(resetn) && $past(ctrl_r[4])
    |-> drive_active_out == $past(devClearReq))
    else $error("deviation clear wrong");
  decel_flag_a: assert property ($past(ctrl_r[5]) &&
    general_outputs_upper[3] |-> $past(decelerating[0]))
    else $error("decel flag wrong");
  accel_flag_a: assert property ($past(ctrl_r[5]) &&
    general_outputs_upper[2] |-> $past(accelerating[0]))
    else $error("accel flag wrong");
  cover property (avs_read && !avs_waitrequest);
  cover property (ctrl_r[5] && general_outputs_upper[0]);
  cover property ($fell(pulseDrive[0]) && ctrl_r[2]);
endmodule
bind aes_axis_outputs aes_axis_monitor aes_axis_monitor_i (.clock,
  .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .pulseDrive, .homeSearch,
  .interpAxis, .interpRun, .driveDir, .minusPulse, .devClearReq,
  .decelerating, .accelerating, .minus_pulse_or_direction_out,
  .drive_active_out, .general_outputs_upper);
`default_nettype wire

// ### testbench/aes_servo_model.sv
// Servo driver and encoder model driving count and in-position pins.
// Assumes callers enter tasks just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module aes_servo_model #(parameter int SETTLE = 6) (
  input wire logic clock, // System clock
  input wire logic [3:0] moving, // Motor commanded to move
  output logic [3:0] phaseA, // Phase A or up pin
  output logic [3:0] phaseB, // Phase B or down pin
  output logic [3:0] inPos // In-position, active high
);
  int ph[4] = '{0, 0, 0, 0}; // Quadrature phase per axis
  int cnt[4] = '{0, 0, 0, 0}; // Settle countdown
  initial begin
    phaseA = 4'h0;
    phaseB = 4'h0;
    inPos = 4'h0;
  end
  // In-position goes active after the motor settles
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (moving[i]) begin
        cnt[i] <= SETTLE;
        inPos[i] <= 1'b0;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
      end else begin
        inPos[i] <= 1'b1;
      end
    end
  end
  // Quadrature steps, A leading B when moving up
  task automatic quad(input int ax, input int n, input bit up);
    repeat (n) begin
      ph[ax] = up ? (ph[ax] + 1) % 4 : (ph[ax] + 3) % 4;
      phaseA[ax] <= (ph[ax] == 1 || ph[ax] == 2);
      phaseB[ax] <= (ph[ax] >= 2);
      repeat (4) @(posedge clock);
    end
  endtask
  // Up or down count pulses
  task automatic updown(input int ax, input int n, input bit up);
    repeat (n) begin
      if (up) phaseA[ax] <= 1'b1;
      else phaseB[ax] <= 1'b1;
      repeat (4) @(posedge clock);
      phaseA[ax] <= 1'b0;
      phaseB[ax] <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench of the axis encoder and status output block.
// Assumes the servo model drives count and in-position pins.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0; // Bus
  logic [5:0] adr = 6'h00; // Address
  logic [31:0] wdat = 32'h0, rdat; // Data
  logic waitReq, irq; // Answers
  logic [3:0] pulseDrive = 0, homeSearch = 0, interpAxis = 0;
  logic [3:0] interpRun = 0, driveDir = 0, minusPulse = 0;
  logic [3:0] devClearReq = 0, decelerating = 0, accelerating = 0;
  logic [127:0] logPos = 128'h0; // Logical counters
  logic [3:0] pinA, pinB, pinPos, minusOut, driveOut; // Pins
  logic [15:0] upper; // Outputs 7..4
  int bad_count = 0, cmp_count = 0; // Tallies
  always #5 clock = ~clock;
  aes_axis_outputs aes_axis_outputs_i (.clock, .resetn,
    .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(waitReq), .irq, .pulseDrive, .homeSearch,
    .interpAxis, .interpRun, .driveDir, .minusPulse, .devClearReq,
    .decelerating, .accelerating, .logicalPos(logPos),
    .phase_a_or_up_count_in(pinA), .phase_b_or_down_count_in(pinB),
    .in_position_in(pinPos), .minus_pulse_or_direction_out(minusOut),
    .drive_active_out(driveOut), .general_outputs_upper(upper));
  aes_servo_model aes_servo_model_i (.clock, .moving(pulseDrive),
    .phaseA(pinA), .phaseB(pinB), .inPos(pinPos));
  task automatic stop_test;
    $display("Comparisons %0d, errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    // Only the watchdog ends a wait that never answers
    do begin
      @(posedge clock);
    end while (waitReq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input string nm, input logic [5:0] a,
                      input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic t_bus;
    rchk("ctrl", aes_pkg::OFF_CTRL, {25'h0, aes_pkg::CTL_RESET});
    wreg(6'h3c, 32'h0000007f);
    rchk("unmapped", 6'h3c, aes_pkg::UNMAPPED_DATA);
    rchk("ctrl kept", aes_pkg::OFF_CTRL, 32'h0);
  endtask
  task automatic t_drive;
    logic [15:0] rows [5] = '{16'h1000, 16'h0200, 16'h00c4,
                              16'h0030, 16'h0000};
    devClearReq <= 4'hf;
    foreach (rows[i]) begin
      {pulseDrive, homeSearch, interpAxis, interpRun} <= rows[i];
      repeat (2) @(posedge clock);
      chk("drive", rows[i][15:12] | rows[i][11:8] |
          (rows[i][7:4] & rows[i][3:0]), driveOut);
    end
    devClearReq <= 4'h9;
    wreg(aes_pkg::OFF_CTRL, 32'h10);
    repeat (2) @(posedge clock);
    chk("clear", 32'h9, driveOut);
    devClearReq <= 4'h0;
  endtask
  task automatic t_minus;
    driveDir <= 4'h5;
    minusPulse <= 4'ha;
    wreg(aes_pkg::OFF_CTRL, 32'h1);
    repeat (2) @(posedge clock);
    chk("minus dir", 32'h5, minusOut);
    wreg(aes_pkg::OFF_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    chk("minus pulse", 32'ha, minusOut);
  endtask
  task automatic t_count;
    wreg(aes_pkg::OFF_CTRL, 32'h2);
    aes_servo_model_i.updown(0, 5, 1'b1);
    aes_servo_model_i.updown(0, 2, 1'b0);
    rchk("updown", aes_pkg::OFF_REALPOS, 32'h3);
    wreg(aes_pkg::OFF_CTRL, 32'h0);
    aes_servo_model_i.quad(0, 7, 1'b1);
    aes_servo_model_i.quad(0, 3, 1'b0);
    rchk("quad", aes_pkg::OFF_REALPOS, 32'h7);
  endtask
  task automatic t_inpos;
    wreg(aes_pkg::OFF_CTRL, 32'h0c);
    pulseDrive <= 4'h1;
    repeat (4) @(posedge clock);
    pulseDrive <= 4'h0;
    repeat (3) @(posedge clock);
    chk("wait inpos", 32'h1, driveOut);
    repeat (20) @(posedge clock);
    chk("inpos done", 32'h0, driveOut);
  endtask
  task automatic t_outdata;
    wreg(aes_pkg::OFF_CTRL, 32'h0);
    wreg(aes_pkg::OFF_AXIS, 32'h0200);
    wreg(aes_pkg::OFF_OUTDATA, 32'h0a00);
    wreg(aes_pkg::OFF_AXIS, 32'h0100);
    wreg(aes_pkg::OFF_OUTDATA, 32'h0500);
    repeat (2) @(posedge clock);
    chk("outputs", 32'h00a5, upper);
  endtask
  task automatic t_status;
    logic [31:0] pos [5] = '{5, 10, 15, 25, 20};
    logic [3:0] exp [5] = '{4'h2, 4'h2, 4'h0, 4'h1, 4'h1};
    wreg(aes_pkg::OFF_CMPLO, 32'd10);
    wreg(aes_pkg::OFF_CMPHI, 32'd20);
    wreg(aes_pkg::OFF_CTRL, 32'h20);
    foreach (pos[i]) begin
      logPos[31:0] <= pos[i];
      repeat (3) @(posedge clock);
      chk("compare", exp[i], upper[3:0]);
    end
    pulseDrive <= 4'h1;
    decelerating <= 4'h1;
    repeat (3) @(posedge clock);
    chk("decel", 32'h9, upper[3:0]);
    decelerating <= 4'h0;
    accelerating <= 4'h1;
    repeat (3) @(posedge clock);
    chk("accel", 32'h5, upper[3:0]);
    accelerating <= 4'h0;
    pulseDrive <= 4'h0;
  endtask
  task automatic t_irq;
    logic [31:0] q;
    bus(1'b0, aes_pkg::OFF_STATUS, 32'h0, q);
    wreg(aes_pkg::OFF_MASK, 32'h1);
    pulseDrive <= 4'h1;
    repeat (4) @(posedge clock);
    pulseDrive <= 4'h0;
    repeat (4) @(posedge clock);
    chk("irq set", 32'h1, irq);
    rchk("status", aes_pkg::OFF_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq clear", 32'h0, irq);
    wreg(aes_pkg::OFF_MASK, 32'h0);
    pulseDrive <= 4'h1;
    repeat (4) @(posedge clock);
    pulseDrive <= 4'h0;
    repeat (4) @(posedge clock);
    chk("irq masked", 32'h0, irq);
  endtask
  // Main sequence, with upper outputs checked inside reset
  initial begin
    repeat (8) @(posedge clock);
    pulseDrive <= 4'hf;
    repeat (8) @(posedge clock);
    chk("reset upper", 32'h0, upper);
    pulseDrive <= 4'h0;
    resetn <= 1'b1;
    t_bus();
    t_drive();
    t_minus();
    t_count();
    t_inpos();
    t_outdata();
    t_status();
    t_irq();
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
